// ### dics_pkg.sv
// dics_pkg: shared constants, state codes and carrier types of the
// dual integrator conversion sequencer.
// assumes interval counts are in system clock periods; phase counts are derived at the 10 MHz reference clock.
package dics_pkg;

  // ****************************************
  // clock
  // ****************************************
  localparam int CLK_PERIOD_PS = 25000;   // 40 MHz system clock
  localparam int REF_PERIOD_PS = 100000;  // 10 MHz clock at which internal times are quoted
  localparam int CNT_W = 14;

  // ****************************************
  // sequencing intervals, in system clock periods
  // ****************************************
  localparam int CONT_MRAZ_PERIODS = 4794;     // cont cycle, also the mode boundary
  localparam int READY_DELAY_PERIODS = 4212;   // select toggle to result ready
  localparam int SECOND_READY_PERIODS = 4548;  // first to second ready of a pair
  localparam int NCONT_MRAZ_PERIODS = 9108;    // both sides after a pair
  localparam int PREPARE_MIN_PERIODS = 240;    // least preparation before integrating

  // ****************************************
  // internal phases, quoted in ns at the 10 MHz reference clock
  // ****************************************
  localparam int CONVERT_TIME_NS = 202200;
  localparam int ADC_RESET_TIME_NS = 13200;
  localparam int CONT_INT_RESET_TIME_NS = 61800;
  localparam int NCONT_INT_RESET_TIME_NS = 37800;
  localparam int NCONT_TOTAL_TIME_NS = 910800;
  localparam logic [CNT_W-1:0] CONVERT_CYC = CNT_W'(CONVERT_TIME_NS * 1000 / REF_PERIOD_PS);
  localparam logic [CNT_W-1:0] ADC_RESET_CYC = CNT_W'(ADC_RESET_TIME_NS * 1000 / REF_PERIOD_PS);
  localparam logic [CNT_W-1:0] CONT_INT_RESET_CYC = CNT_W'(CONT_INT_RESET_TIME_NS * 1000 / REF_PERIOD_PS);
  localparam logic [CNT_W-1:0] NCONT_INT_RESET_CYC = CNT_W'(NCONT_INT_RESET_TIME_NS * 1000 / REF_PERIOD_PS);
  localparam logic [CNT_W-1:0] NCONT_TOTAL_CYC = CNT_W'(NCONT_TOTAL_TIME_NS * 1000 / REF_PERIOD_PS);

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [CNT_W-1:0] CNT_RST = 14'h0000;
  localparam logic [1:0] PHASE_RST = 2'h0;

  // sequencer states; bit n-1 set means state n, so state n and 9-n mirror
  typedef enum logic [7:0] {
    DICS_S1 = 8'h01,
    DICS_S2 = 8'h02,
    DICS_S3 = 8'h04,
    DICS_S4 = 8'h08,
    DICS_S5 = 8'h10,
    DICS_S6 = 8'h20,
    DICS_S7 = 8'h40,
    DICS_S8 = 8'h80
  } dics_state_e;

  // phase of the running measure_reset_autozero cycle
  typedef enum logic [1:0] {
    DICS_PH_IDLE = 2'h0,
    DICS_PH_CONVERT = 2'h1,
    DICS_PH_ADC_RESET = 2'h2,
    DICS_PH_INT_RESET = 2'h3
  } dics_phase_e;

  // sequencer status seen outside
  typedef struct packed {
    logic integrating_a;
    logic integrating_b;
    logic measure_busy;
    logic noncontinuous;
    dics_phase_e phase;
  } dics_status_s;

  localparam dics_status_s STATUS_RST = '{1'b0, 1'b0, 1'b0, 1'b0, DICS_PH_IDLE};

endpackage

// ### dics_timer.sv
// dics_timer: loadable down counter with registered busy level and done pulse.
// assumes load and value are synchronous to CLK; a load restarts a running count.
`timescale 1ns/1ps
`default_nettype none
module dics_timer
  import dics_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [dics_pkg::CNT_W-1:0] value,
  // status
  output logic [dics_pkg::CNT_W-1:0] remain,
  output logic busy,
  output logic done
);

  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;

  // count down to zero; done is one cycle wide, in the first cycle the count reads zero
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    if (load) begin
      nxt_cnt = value;
    end else if (cnt_ff != CNT_RST) begin
      nxt_cnt = cnt_ff - 14'h0001;
      nxt_done = (cnt_ff == 14'h0001);
    end
    nxt_busy = (nxt_cnt != CNT_RST);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= CNT_RST;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign remain = cnt_ff;
  assign busy = busy_ff;
  assign done = done_ff;

endmodule
`default_nettype wire

// ### dics_ready_flag.sv
// dics_ready_flag: active-low result ready flag with its side tag.
// assumes transmit_enable_n is synchronous; a set in the clearing cycle wins.
`timescale 1ns/1ps
`default_nettype none
module dics_ready_flag (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // events
  input wire logic set,
  input wire logic set_side_b,
  input wire logic transmit_enable_n,
  // flag
  output logic ready_n,
  output logic side_b
);

  logic ready_n_ff, nxt_ready_n;
  logic side_b_ff, nxt_side_b;

  // low on a new result, high again once the controller starts a transfer
  always_comb begin
    nxt_ready_n = ready_n_ff;
    nxt_side_b = side_b_ff;
    if (set) begin
      nxt_ready_n = 1'b0;
      nxt_side_b = set_side_b;
    end else if (!transmit_enable_n) begin
      nxt_ready_n = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_n_ff <= 1'b1;
      side_b_ff <= 1'b0;
    end else begin
      ready_n_ff <= nxt_ready_n;
      side_b_ff <= nxt_side_b;
    end
  end

  assign ready_n = ready_n_ff;
  assign side_b = side_b_ff;

endmodule
`default_nettype wire

// ### dics_sequencer.sv
// dics_sequencer: eight-state integrate / measure_reset_autozero sequencer.
// assumes INTEGRATE_SELECT and TRANSMIT_ENABLE_N change synchronously to CLK.
// Operation
// - Continuous measure_reset_autozero cycle lasts 4794 clocks; also the mode boundary.
// - Continuous mode: result ready 4212 clocks after the select toggle.
// - Non-continuous: first ready 4212 clocks after first integration of pair ends.
// - Non-continuous: second ready exactly 4548 clocks after the first.
// - Non-continuous: both sides' cycles take 9108 clocks after a pair.
// - Next side needs at least 240 clocks of preparation before integrating.
// - Ready held low until the controller drives transmit enable low.
// - Power-up enters state 1 with select high, state 8 with select low.
// - With long periods the sequencer settles alternating states 4 and 5.
// - Inverted select differs only in the first three states.
// - Non-continuous integrations come in pairs; states 1 and 8 wait for both cycles.
// - Typical non-continuous sequence repeats 3, 4, 1, 2.
// - States 1 and 8 ignore select until measure busy falls.
// - State 2 goes to 3 as soon as select is high, no minimum.
// - Too short a period switches to non-continuous via states 1, 2, 3 or 8, 7, 6.
// - Long enough periods return to continuous; first integration may be short.
// - Continuous cycle: conversion 202.2 us, converter reset 13.2, integrator reset 61.8.
// - Non-continuous cycles total 910.8 us; integrator reset portion 37.8 us.
// - Advances on select level together with the internal measure busy.
// - Toggle while busy enters or keeps state 1 or 8, then 2 or 7.
// - Integrations always alternate between side A and side B.
`timescale 1ns/1ps
`default_nettype none
module dics_sequencer
  import dics_pkg::*;
#(
  parameter logic [dics_pkg::CNT_W-1:0] CONT_MRAZ_CYC = 14'(dics_pkg::CONT_MRAZ_PERIODS),
  parameter logic [dics_pkg::CNT_W-1:0] READY_DELAY_CYC = 14'(dics_pkg::READY_DELAY_PERIODS),
  parameter logic [dics_pkg::CNT_W-1:0] SECOND_READY_CYC = 14'(dics_pkg::SECOND_READY_PERIODS),
  parameter logic [dics_pkg::CNT_W-1:0] NCONT_MRAZ_CYC = 14'(dics_pkg::NCONT_MRAZ_PERIODS)
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // controller side
  input wire logic INTEGRATE_SELECT,
  input wire logic TRANSMIT_ENABLE_N,
  output logic RESULT_READY_N,
  output logic RESULT_SIDE_B,
  // sequencer view
  output dics_pkg::dics_state_e STATE,
  output dics_pkg::dics_status_s STATUS,
  output logic PREPARE_SHORT
);
  import dics_pkg::*;

  // ****************************************
  // state and events
  // ****************************************
  dics_state_e state_ff, nxt_state;
  logic boot_ff, nxt_boot;
  logic ncont_ff, nxt_ncont;
  logic second_pend_ff, nxt_second_pend;
  logic first_side_b_ff, nxt_first_side_b;
  logic [7:0] prep_cnt_ff, nxt_prep_cnt;
  logic prep_short_ff, nxt_prep_short;
  dics_status_s status_ff, nxt_status;

  logic busy_load, ready1_load, ready2_load;
  logic [CNT_W-1:0] busy_value;
  logic [CNT_W-1:0] busy_remain;
  logic mbusy, ready1_done, ready2_done;
  logic ready_set, ready_set_side_b;

  localparam logic [7:0] PREP_CYC = 8'(PREPARE_MIN_PERIODS);
  // timers load one less than the interval; the loading edge is its first period
  localparam logic [CNT_W-1:0] CONT_BUSY_LOAD = CONT_MRAZ_CYC - 14'h0001;
  localparam logic [CNT_W-1:0] NCONT_BUSY_LOAD = NCONT_MRAZ_CYC - 14'h0001;
  localparam logic [CNT_W-1:0] READY1_LOAD = READY_DELAY_CYC - 14'h0001;
  localparam logic [CNT_W-1:0] READY2_LOAD = SECOND_READY_CYC - 14'h0001;

  // ****************************************
  // timers
  // ****************************************
  // measure busy: one timer serves both sides, reloaded per cycle
  dics_timer u_busy (
    .clk(CLK),
    .rst(RST),
    .load(busy_load),
    .value(busy_value),
    .remain(busy_remain),
    .busy(mbusy),
    .done()
  );

  // first ready of a result, from the end of an integration
  dics_timer u_ready1 (
    .clk(CLK),
    .rst(RST),
    .load(ready1_load),
    .value(READY1_LOAD),
    .remain(),
    .busy(),
    .done(ready1_done)
  );

  // second ready of a non-continuous pair, from the first ready
  dics_timer u_ready2 (
    .clk(CLK),
    .rst(RST),
    .load(ready2_load),
    .value(READY2_LOAD),
    .remain(),
    .busy(),
    .done(ready2_done)
  );

  // ****************************************
  // state machine
  // ****************************************
  // level driven: select level and measure busy pick the next state
  always_comb begin
    nxt_state = state_ff;
    nxt_boot = 1'b0;
    nxt_ncont = ncont_ff;
    nxt_second_pend = second_pend_ff & !ready2_done; // a pair end below wins over the clear
    nxt_first_side_b = first_side_b_ff;
    busy_load = 1'b0;
    busy_value = CONT_BUSY_LOAD;
    ready1_load = 1'b0;
    if (boot_ff) begin
      // power-up always lands in a non-continuous state
      nxt_state = INTEGRATE_SELECT ? DICS_S1 : DICS_S8;
    end else begin
      case (state_ff)
        DICS_S1: begin
          if (!mbusy) begin
            nxt_state = DICS_S2;
          end
        end
        DICS_S2: begin
          if (INTEGRATE_SELECT) begin
            nxt_state = DICS_S3;
          end
        end
        DICS_S3: begin
          if (!INTEGRATE_SELECT) begin
            // side A ends, its cycle runs while B integrates
            nxt_state = DICS_S4;
            busy_load = 1'b1;
            ready1_load = 1'b1;
            nxt_first_side_b = 1'b0;
          end
        end
        DICS_S4: begin
          if (INTEGRATE_SELECT && mbusy) begin
            // period too short: pair ends, both sides measured together
            nxt_state = DICS_S1;
            busy_load = 1'b1;
            busy_value = NCONT_BUSY_LOAD;
            nxt_ncont = 1'b1;
            nxt_second_pend = 1'b1;
          end else if (INTEGRATE_SELECT) begin
            nxt_state = DICS_S5;
            busy_load = 1'b1;
            ready1_load = 1'b1;
            nxt_first_side_b = 1'b1;
            nxt_ncont = 1'b0;
          end
        end
        DICS_S5: begin
          if (!INTEGRATE_SELECT && mbusy) begin
            nxt_state = DICS_S8;
            busy_load = 1'b1;
            busy_value = NCONT_BUSY_LOAD;
            nxt_ncont = 1'b1;
            nxt_second_pend = 1'b1;
          end else if (!INTEGRATE_SELECT) begin
            nxt_state = DICS_S4;
            busy_load = 1'b1;
            ready1_load = 1'b1;
            nxt_first_side_b = 1'b0;
            nxt_ncont = 1'b0;
          end
        end
        DICS_S6: begin
          if (INTEGRATE_SELECT) begin
            nxt_state = DICS_S5;
            busy_load = 1'b1;
            ready1_load = 1'b1;
            nxt_first_side_b = 1'b1;
          end
        end
        DICS_S7: begin
          if (!INTEGRATE_SELECT) begin
            nxt_state = DICS_S6;
          end
        end
        DICS_S8: begin
          if (!mbusy) begin
            nxt_state = DICS_S7;
          end
        end
        default: begin
          nxt_state = INTEGRATE_SELECT ? DICS_S1 : DICS_S8;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_ff <= DICS_S1;
      boot_ff <= 1'b1;
      ncont_ff <= 1'b0;
      second_pend_ff <= 1'b0;
      first_side_b_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      boot_ff <= nxt_boot;
      ncont_ff <= nxt_ncont;
      second_pend_ff <= nxt_second_pend;
      first_side_b_ff <= nxt_first_side_b;
    end
  end

  // ****************************************
  // result ready
  // ****************************************
  // second timer always starts with a first ready; it sets the flag only if a pair owes it.
  // in continuous mode the next toggle supplies the next result instead.
  assign ready2_load = ready1_done;
  assign ready_set = ready1_done | (ready2_done & second_pend_ff);
  assign ready_set_side_b = ready1_done ? first_side_b_ff : !first_side_b_ff;

  dics_ready_flag u_flag (
    .clk(CLK),
    .rst(RST),
    .set(ready_set),
    .set_side_b(ready_set_side_b),
    .transmit_enable_n(TRANSMIT_ENABLE_N),
    .ready_n(RESULT_READY_N),
    .side_b(RESULT_SIDE_B)
  );

  // ****************************************
  // preparation watch and status
  // ****************************************
  // the sequencer does not stall a short state 2 or 7; it only flags it,
  // since meeting the preparation time is the controller's duty
  always_comb begin
    nxt_prep_cnt = prep_cnt_ff;
    nxt_prep_short = prep_short_ff;
    if (state_ff == DICS_S2 || state_ff == DICS_S7) begin
      if (prep_cnt_ff != PREP_CYC) begin
        nxt_prep_cnt = prep_cnt_ff + 8'h01;
      end
      if (nxt_state != state_ff) begin
        nxt_prep_short = (prep_cnt_ff + 8'h01 < PREP_CYC);
      end
    end else begin
      nxt_prep_cnt = 8'h00;
    end
  end

  // phase of the cycle from its elapsed time; the integrator reset figure differs by mode
  always_comb begin
    logic [CNT_W-1:0] elapsed;
    logic [CNT_W-1:0] int_reset;
    elapsed = CNT_RST;
    int_reset = ncont_ff ? NCONT_INT_RESET_CYC : CONT_INT_RESET_CYC;
    nxt_status.integrating_a = (nxt_state == DICS_S3) || (nxt_state == DICS_S5);
    nxt_status.integrating_b = (nxt_state == DICS_S4) || (nxt_state == DICS_S6);
    nxt_status.measure_busy = mbusy;
    nxt_status.noncontinuous = nxt_ncont;
    nxt_status.phase = DICS_PH_IDLE;
    if (mbusy) begin
      elapsed = (ncont_ff ? NCONT_MRAZ_CYC : CONT_MRAZ_CYC) - busy_remain;
      if (ncont_ff && elapsed >= (NCONT_MRAZ_CYC >> 1)) begin
        // second side of a pair starts its own conversion halfway
        elapsed = elapsed - (NCONT_MRAZ_CYC >> 1);
      end
      if (elapsed < CONVERT_CYC) begin
        nxt_status.phase = DICS_PH_CONVERT;
      end else if (elapsed < CONVERT_CYC + ADC_RESET_CYC) begin
        nxt_status.phase = DICS_PH_ADC_RESET;
      end else if (elapsed < CONVERT_CYC + ADC_RESET_CYC + int_reset) begin
        nxt_status.phase = DICS_PH_INT_RESET;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prep_cnt_ff <= 8'h00;
      prep_short_ff <= 1'b0;
      status_ff <= STATUS_RST;
    end else begin
      prep_cnt_ff <= nxt_prep_cnt;
      prep_short_ff <= nxt_prep_short;
      status_ff <= nxt_status;
    end
  end

  assign STATE = state_ff;
  assign STATUS = status_ff;
  assign PREPARE_SHORT = prep_short_ff;

endmodule
`default_nettype wire

// ### dics_sequencer_sva.sv
// dics_sequencer_sva: port checks for the conversion sequencer.
// assumes the bind below; parameters follow the bound instance.
`timescale 1ns/1ps
`default_nettype none
module dics_sequencer_sva
  import dics_pkg::*;
#(
  parameter logic [13:0] CONT_MRAZ_CYC = 14'h12ba,
  parameter logic [13:0] READY_DELAY_CYC = 14'h1074,
  parameter logic [13:0] SECOND_READY_CYC = 14'h11c4,
  parameter logic [13:0] NCONT_MRAZ_CYC = 14'h2394
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // controller side
  input wire logic INTEGRATE_SELECT,
  input wire logic TRANSMIT_ENABLE_N,
  input wire logic RESULT_READY_N,
  input wire logic RESULT_SIDE_B,
  // sequencer view
  input wire dics_pkg::dics_state_e STATE,
  input wire dics_pkg::dics_status_s STATUS,
  input wire logic PREPARE_SHORT
);
  // ****************************************
  // properties
  // ****************************************
  // the ready delay runs to thousands of cycles, so it is counted here, not in a delay range
  dics_state_e prev_state_ff;
  logic [13:0] rd_wait_ff;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prev_state_ff <= DICS_S1;
      rd_wait_ff <= 14'h0000;
    end else begin
      prev_state_ff <= STATE;
      if (prev_state_ff == DICS_S3 && STATE == DICS_S4) begin
        rd_wait_ff <= READY_DELAY_CYC;
      end else if (rd_wait_ff != 14'h0000) begin
        rd_wait_ff <= rd_wait_ff - 14'h0001;
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  a_powerup_state: assert property ($past(RST) && !RST |=>
    STATE == ($past(INTEGRATE_SELECT) ? DICS_S1 : DICS_S8)) else $error("wrong power-up state");
  // the first edge after release may leave the reset code, so it is excluded
  a_hold_s1: assert property (STATE == DICS_S1 && !$past(RST) |=> STATE inside {DICS_S1, DICS_S2})
    else $error("state 1 left early");
  a_hold_s8: assert property (STATE == DICS_S8 |=> STATE inside {DICS_S8, DICS_S7})
    else $error("state 8 left early");
  a_prep_exit: assert property (STATE == DICS_S2 && INTEGRATE_SELECT |=> STATE == DICS_S3)
    else $error("state 2 stalled");
  a_prep_mirror: assert property (STATE == DICS_S7 && !INTEGRATE_SELECT |=> STATE == DICS_S6)
    else $error("state 7 stalled");
  a_integ_a_hold: assert property (STATE == DICS_S3 && INTEGRATE_SELECT |=> STATE == DICS_S3)
    else $error("state 3 left without select");
  a_side_alternate: assert property (STATE == DICS_S4 && INTEGRATE_SELECT |=>
    STATE inside {DICS_S1, DICS_S5}) else $error("side b not followed by side a");
  a_ready_hold: assert property (!RESULT_READY_N && TRANSMIT_ENABLE_N |=> !RESULT_READY_N)
    else $error("ready released without transmit enable");
  a_state_onehot: assert property ($onehot(STATE))
    else $error("state code not one-hot");
  a_ready_delay: assert property (rd_wait_ff == 14'h0001 |-> $fell(RESULT_READY_N))
    else $error("first ready off time");
  c_cont_swap: cover property ($past(STATE) == DICS_S4 && STATE == DICS_S5);
  c_pair_end: cover property ($past(STATE) == DICS_S4 && STATE == DICS_S1);
  c_ready: cover property ($fell(RESULT_READY_N));
endmodule
bind dics_sequencer dics_sequencer_sva #(.CONT_MRAZ_CYC(CONT_MRAZ_CYC), .READY_DELAY_CYC(READY_DELAY_CYC),
  .SECOND_READY_CYC(SECOND_READY_CYC), .NCONT_MRAZ_CYC(NCONT_MRAZ_CYC)) u_dics_sequencer_sva (.CLK(CLK),
  .RST(RST), .INTEGRATE_SELECT(INTEGRATE_SELECT), .TRANSMIT_ENABLE_N(TRANSMIT_ENABLE_N),
  .RESULT_READY_N(RESULT_READY_N), .RESULT_SIDE_B(RESULT_SIDE_B), .STATE(STATE), .STATUS(STATUS),
  .PREPARE_SHORT(PREPARE_SHORT));
`default_nettype wire

// ### dics_host.sv
// dics_host: behavioural controller driving integrate select and acknowledging results.
// assumes the bench sets its controls at rising edges.
`timescale 1ns/1ps
`default_nettype none
module dics_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // scenario control
  input wire logic run,
  input wire logic init_level,
  input wire logic [15:0] half_period,
  input wire logic ack_on,
  // device side
  input wire logic result_ready_n,
  output logic integrate_select,
  output logic transmit_enable_n
);
  // ****************************************
  // select square wave and acknowledge
  // ****************************************
  logic [15:0] count_ff;
  // >= so that shortening the period mid-count cannot run the counter round
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= 16'h0000;
      integrate_select <= init_level;
    end else if (run && count_ff >= half_period - 16'h0001) begin
      count_ff <= 16'h0000;
      integrate_select <= !integrate_select;
    end else if (run) begin
      count_ff <= count_ff + 16'h0001;
    end
  end
  // one-cycle low pulse per result, so a later result is never swallowed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transmit_enable_n <= 1'b1;
    end else begin
      transmit_enable_n <= !(ack_on && !result_ready_n && transmit_enable_n);
    end
  end
endmodule
`default_nettype wire

// ### dics_sequencer_test.sv
// dics_sequencer_test: self-checking bench for the sequencer.
// assumes dics_host as controller; counts scaled down by parameter.
`timescale 1ns/1ps
`default_nettype none
module dics_sequencer_test;
  import dics_pkg::*;
  // ****************************************
  // setup
  // ****************************************
  localparam logic [13:0] P_CONT = 14'h003c;
  localparam logic [13:0] P_RDY = 14'h0032;
  localparam logic [13:0] P_SEC = 14'h0037;
  localparam logic [13:0] P_NC = 14'h006e;
  logic CLK, RST, run, init_level, ack_on, prev_rdy;
  logic [15:0] half_period;
  logic INTEGRATE_SELECT, TRANSMIT_ENABLE_N, RESULT_READY_N, RESULT_SIDE_B, PREPARE_SHORT;
  dics_state_e STATE, prev_state;
  dics_status_s STATUS;
  int bad_count, check_count, cyc, rs_cnt, last_chg, s1_len, n_s1, n_s8, n_s45;
  int fall_t[$];
  int fall_d[$];
  logic fall_side[$];

  dics_sequencer #(.CONT_MRAZ_CYC(P_CONT), .READY_DELAY_CYC(P_RDY), .SECOND_READY_CYC(P_SEC),
    .NCONT_MRAZ_CYC(P_NC)) u_dics_sequencer (.CLK(CLK), .RST(RST), .INTEGRATE_SELECT(INTEGRATE_SELECT),
    .TRANSMIT_ENABLE_N(TRANSMIT_ENABLE_N), .RESULT_READY_N(RESULT_READY_N), .RESULT_SIDE_B(RESULT_SIDE_B),
    .STATE(STATE), .STATUS(STATUS), .PREPARE_SHORT(PREPARE_SHORT));
  dics_host u_dics_host (.clk(CLK), .rst(RST), .run(run), .init_level(init_level),
    .half_period(half_period), .ack_on(ack_on), .result_ready_n(RESULT_READY_N),
    .integrate_select(INTEGRATE_SELECT), .transmit_enable_n(TRANSMIT_ENABLE_N));

  initial CLK = 1'b0;
  always #12.5 CLK = ~CLK;

  task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_num(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic legal(input dics_state_e a, input dics_state_e b);
    case (a)
      DICS_S1: return b == DICS_S2;
      DICS_S2: return b == DICS_S3;
      DICS_S3: return b == DICS_S4;
      DICS_S4: return b inside {DICS_S1, DICS_S5};
      DICS_S5: return b inside {DICS_S8, DICS_S4};
      DICS_S6: return b == DICS_S5;
      DICS_S7: return b == DICS_S6;
      default: return b == DICS_S7;
    endcase
  endfunction

  // ****************************************
  // monitor: successors, counts, flag falls, hang guard
  // ****************************************
  always @(posedge CLK) begin
    #1;
    cyc++;
    rs_cnt = RST ? 0 : rs_cnt + 1;
    if (cyc > 8000) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, cyc, 8000);
      end_of_test();
    end
    // the edge leaving the reset code is not a sequencer step
    if (rs_cnt > 2 && STATE !== prev_state) begin
      check_vec(8'(legal(prev_state, STATE)), 8'h01);
      if (prev_state === DICS_S1) s1_len = cyc - last_chg;
      n_s1 += int'(STATE === DICS_S1);
      n_s8 += int'(STATE === DICS_S8);
      n_s45 += int'(STATE inside {DICS_S4, DICS_S5} && prev_state inside {DICS_S4, DICS_S5});
      last_chg = cyc;
    end
    // states 3 and 5 integrate side a, states 4 and 6 side b
    if (rs_cnt > 2) check_vec({6'h00, STATUS.integrating_a, STATUS.integrating_b},
      {6'h00, (STATE inside {DICS_S3, DICS_S5}), (STATE inside {DICS_S4, DICS_S6})});
    if (prev_rdy === 1'b1 && RESULT_READY_N === 1'b0) begin
      fall_t.push_back(cyc);
      fall_d.push_back(cyc - last_chg);
      fall_side.push_back(RESULT_SIDE_B);
    end
    prev_rdy = RESULT_READY_N;
    prev_state = STATE;
  end

  // ****************************************
  // scenarios
  // ****************************************
  task automatic do_reset(input logic lvl, input logic [15:0] half);
    @(posedge CLK);
    run <= 1'b0;
    init_level <= lvl;
    half_period <= half;
    ack_on <= 1'b1;
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    check_vec({5'h00, RESULT_READY_N, RESULT_SIDE_B, PREPARE_SHORT}, 8'h04);
    check_vec({2'h0, STATUS}, {2'h0, STATUS_RST});
    @(posedge CLK);
    RST <= 1'b0;
    n_s1 = 0;
    n_s8 = 0;
    n_s45 = 0;
    fall_t.delete();
    fall_d.delete();
    fall_side.delete();
  endtask
  // falls alternate sides; continuous delay from toggle, or the gap inside a pair
  task automatic check_falls(input logic pair);
    check_num(fall_t.size(), 4, 99);
    for (int k = 1; k < fall_t.size(); k++) begin
      check_vec(8'(fall_side[k]), 8'(!fall_side[k-1]));
      if (!pair) check_num(fall_d[k], int'(P_RDY), int'(P_RDY));
      else if (!fall_side[k-1]) check_num(fall_t[k] - fall_t[k-1], int'(P_SEC), int'(P_SEC));
    end
  endtask
  task automatic t_powerup(input logic lvl);
    do_reset(lvl, 16'h0050);
    for (int k = 0; k < 3; k++) begin
      @(posedge CLK);
      #1;
      check_vec(STATE, lvl ? 8'h01 << k : 8'h80 >> k);
    end
    $display("test powerup %0d done", lvl);
  endtask
  task automatic t_cont(input logic [15:0] half);
    do_reset(1'b1, half);
    run <= 1'b1;
    repeat (1200) @(posedge CLK);
    #1;
    check_num(n_s1 + n_s8, 0, 0);
    check_num(n_s45, 10, 99);
    check_falls(1'b0);
    $display("test continuous %0d done", half);
  endtask
  task automatic t_noncont();
    do_reset(1'b1, 16'h001e);
    run <= 1'b1;
    repeat (1500) @(posedge CLK);
    #1;
    check_num(n_s45, 0, 0);
    check_num(n_s1, 4, 99);
    check_num(s1_len, int'(P_NC), int'(P_NC));
    check_vec(8'(PREPARE_SHORT), 8'h01);
    check_falls(1'b1);
    $display("test noncontinuous done");
  endtask
  task automatic t_modes();
    do_reset(1'b1, 16'h0050);
    run <= 1'b1;
    repeat (500) @(posedge CLK);
    half_period <= 16'h001e;
    repeat (700) @(posedge CLK);
    #1;
    check_num(n_s1 + n_s8, 1, 99);
    n_s45 = 0;
    @(posedge CLK);
    half_period <= 16'h0050;
    repeat (700) @(posedge CLK);
    #1;
    check_num(n_s45, 3, 99);
    $display("test mode change done");
  endtask
  task automatic t_hold();
    do_reset(1'b1, 16'h0050);
    ack_on <= 1'b0;
    run <= 1'b1;
    for (int k = 0; k < 400 && RESULT_READY_N !== 1'b0; k++) begin
      @(posedge CLK);
      #1;
    end
    repeat (40) @(posedge CLK);
    #1;
    check_vec(8'(RESULT_READY_N), 8'h00);
    @(posedge CLK);
    ack_on <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    check_vec(8'(RESULT_READY_N), 8'h01);
    $display("test ready hold done");
  endtask

  initial begin
    RST = 1'b1;
    run = 1'b0;
    init_level = 1'b1;
    ack_on = 1'b1;
    half_period = 16'h0050;
    t_powerup(1'b1);
    t_powerup(1'b0);
    t_cont(16'h0050);
    t_cont(16'h003c);
    t_noncont();
    t_modes();
    t_hold();
    end_of_test();
  end
endmodule
`default_nettype wire
